// [uwtb_pkg.sv]
package uwtb_pkg;

   // ***************************************************************
   // Register offsets (byte addresses)
   // ***************************************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DATA = 8'h04;
   localparam logic [7:0] OFS_TMR = 8'h08;
   localparam logic [7:0] OFS_RELOAD = 8'h0c;
   localparam logic [7:0] OFS_STAT = 8'h10;
   localparam logic [7:0] OFS_MASK = 8'h14;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int CTRL_MODE_BIT = 7;
   localparam int CTRL_MCE_BIT = 5;
   localparam int CTRL_REN_BIT = 4;
   localparam int CTRL_TB8_BIT = 3;
   localparam int STAT_RX_BIT = 0;
   localparam int STAT_TX_BIT = 1;
   localparam int TMR_RUN_BIT = 0;
   localparam int TMR_SEL_LSB = 1;

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] RELOAD_RST = 8'h00;
   localparam logic [1:0] FLAG_RST = 2'h0;
   localparam logic [1:0] MASK_RST = 2'h0;
   localparam logic UNUSED_BIT_VAL = 1'b1;

   // ***************************************************************
   // Timer clock dividers and bus codes
   // ***************************************************************
   localparam logic [5:0] PRE_DIV4 = 6'h04;
   localparam logic [5:0] PRE_DIV12 = 6'h0c;
   localparam logic [5:0] PRE_DIV48 = 6'h30;
   localparam logic [2:0] EXT_DIV8_LAST = 3'h7;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   typedef enum logic [1:0] {
      UWTB_SRC_D4,
      UWTB_SRC_D12,
      UWTB_SRC_D48,
      UWTB_SRC_EXT8
   } uwtb_src_e;

   typedef struct packed {
      logic frame9;
      logic mce;
      logic ren;
      logic tb8;
   } uwtb_ctrl_s;

   typedef struct packed {
      logic sel;
      logic wr;
      logic [7:0] ofs;
   } uwtb_aphase_s;

endpackage

// [uwtb_baud_cnt.sv]
`timescale 1ns/10ps
module uwtb_baud_cnt #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic tick,
   input wire logic force_load,
   input wire logic [W-1:0] reload,
   output logic [W-1:0] count,
   output logic baud_en
);
   logic [W-1:0] count_ff;
   logic half_ff;
   wire ovf = tick & (count_ff == {W{1'b1}});

   // A forced reload primes the halver so the first overflow lands
   // half a bit after the start edge
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         count_ff <= '0;
         half_ff <= 1'b0;
      end else if (force_load) begin
         count_ff <= reload;
         half_ff <= 1'b1;
      end else if (ovf) begin
         count_ff <= reload;
         half_ff <= ~half_ff;
      end else if (tick) begin
         count_ff <= count_ff + 1'b1;
      end
   end

   assign baud_en = ovf & half_ff & ~force_load;
   assign count = count_ff;
endmodule

// [uwtb_top.sv]
`timescale 1ns/10ps
module uwtb_top #(
   parameter int DATA_BITS = 8
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic ext_clk_en,
   input wire logic rx_pin,
   output logic tx_pin,
   output logic irq
);
   import uwtb_pkg::*;

   typedef enum logic [2:0] {
      TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP
   } uwtb_tx_e;
   typedef enum logic [2:0] {
      RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP
   } uwtb_rx_e;

   // ***************************************************************
   // Bus slave
   // ***************************************************************
   uwtb_aphase_s aph_ff;
   uwtb_aphase_s nxt_aph;
   wire addr_take = hsel & hready & htrans[1];

   assign nxt_aph.sel = addr_take & (hsize == HSIZE_WORD)
                        & (haddr[31:8] == 24'h000000);
   assign nxt_aph.wr = hwrite;
   assign nxt_aph.ofs = haddr[7:0];

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         aph_ff <= '0;
      else if (hready)
         aph_ff <= nxt_aph;
   end

   wire wr_en = aph_ff.sel & aph_ff.wr;
   wire rd_en = aph_ff.sel & ~aph_ff.wr;
   wire wr_ctrl = wr_en & (aph_ff.ofs == OFS_CTRL);
   wire wr_data = wr_en & (aph_ff.ofs == OFS_DATA);
   wire wr_tmr = wr_en & (aph_ff.ofs == OFS_TMR);
   wire wr_reload = wr_en & (aph_ff.ofs == OFS_RELOAD);
   wire wr_stat = wr_en & (aph_ff.ofs == OFS_STAT);
   wire wr_mask = wr_en & (aph_ff.ofs == OFS_MASK);

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ***************************************************************
   // Registers
   // ***************************************************************
   uwtb_ctrl_s ctrl_ff;
   uwtb_src_e src_ff;
   logic run_ff;
   logic [7:0] reload_ff;
   logic [7:0] rxbuf_ff;
   logic rb8_ff;
   logic [1:0] stat_ff;
   logic [1:0] mask_ff;
   logic tx_set;
   logic rx_set;
   logic rx_load;
   logic [7:0] rx_load_data;
   logic rx_load_b8;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_ff <= '0;
         src_ff <= UWTB_SRC_D4;
         run_ff <= 1'b0;
         reload_ff <= RELOAD_RST;
         mask_ff <= MASK_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff.frame9 <= hwdata[CTRL_MODE_BIT];
            ctrl_ff.mce <= hwdata[CTRL_MCE_BIT];
            ctrl_ff.ren <= hwdata[CTRL_REN_BIT];
            ctrl_ff.tb8 <= hwdata[CTRL_TB8_BIT];
         end
         if (wr_tmr) begin
            run_ff <= hwdata[TMR_RUN_BIT];
            src_ff <= uwtb_src_e'(hwdata[TMR_SEL_LSB +: 2]);
         end
         if (wr_reload)
            reload_ff <= hwdata[7:0];
         if (wr_mask)
            mask_ff <= hwdata[1:0];
      end
   end

   // Set wins over a write-one clear in the same cycle
   wire [1:0] flag_clr = wr_stat ? hwdata[1:0] : 2'h0;
   wire [1:0] nxt_stat = (stat_ff & ~flag_clr) | {tx_set, rx_set};

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stat_ff <= FLAG_RST;
         rxbuf_ff <= DATA_RST;
         rb8_ff <= 1'b0;
      end else begin
         stat_ff <= nxt_stat;
         if (rx_load) begin
            rxbuf_ff <= rx_load_data;
            rb8_ff <= rx_load_b8;
         end
      end
   end

   assign irq = |(stat_ff & mask_ff);

   // ***************************************************************
   // Timer clock prescaler
   // ***************************************************************
   logic [5:0] pre_cnt_ff;
   logic [2:0] ext_cnt_ff;
   wire use_ext = (src_ff == UWTB_SRC_EXT8);
   wire [5:0] pre_lim = (src_ff == UWTB_SRC_D12) ? PRE_DIV12 :
                        (src_ff == UWTB_SRC_D48) ? PRE_DIV48 : PRE_DIV4;
   wire pre_hit = (pre_cnt_ff == pre_lim - 6'h01);
   wire ext_hit = ext_clk_en & (ext_cnt_ff == EXT_DIV8_LAST);
   wire tmr_tick = run_ff & (use_ext ? ext_hit : pre_hit);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pre_cnt_ff <= '0;
         ext_cnt_ff <= '0;
      end else begin
         pre_cnt_ff <= (!run_ff || pre_hit) ? 6'h00 : pre_cnt_ff + 6'h01;
         if (!run_ff)
            ext_cnt_ff <= '0;
         else if (ext_clk_en)
            ext_cnt_ff <= ext_cnt_ff + 3'h1;
      end
   end

   // ***************************************************************
   // Baud counters
   // ***************************************************************
   logic [7:0] low_count;
   logic tx_baud;
   logic rx_baud;
   logic rx_start_det;

   uwtb_baud_cnt #(.W(8)) u_tx_cnt (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(tmr_tick),
      .force_load(1'b0),
      .reload(reload_ff),
      .count(low_count),
      .baud_en(tx_baud)
   );

   uwtb_baud_cnt #(.W(8)) u_rx_cnt (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(tmr_tick),
      .force_load(rx_start_det),
      .reload(reload_ff),
      .count(),
      .baud_en(rx_baud)
   );

   // ***************************************************************
   // Transmitter
   // ***************************************************************
   uwtb_tx_e tx_st_ff, nxt_tx_st;
   logic [7:0] tx_sh_ff, nxt_tx_sh;
   logic [3:0] tx_cnt_ff, nxt_tx_cnt;
   logic tx_pend_ff, nxt_tx_pend;
   logic tx_pin_ff, nxt_tx_pin;
   wire tx_free = ~tx_pend_ff & ((tx_st_ff == TX_IDLE)
                  | (tx_st_ff == TX_STOP));
   wire tx_load = wr_data & tx_free;

   always_comb begin
      nxt_tx_st = tx_st_ff;
      nxt_tx_sh = tx_load ? hwdata[7:0] : tx_sh_ff;
      nxt_tx_cnt = tx_cnt_ff;
      nxt_tx_pend = tx_pend_ff | tx_load;
      nxt_tx_pin = tx_pin_ff;
      tx_set = 1'b0;
      if (tx_baud) begin
         case (tx_st_ff)
            TX_IDLE, TX_STOP: begin
               if (tx_pend_ff) begin
                  nxt_tx_st = TX_START;
                  nxt_tx_pin = 1'b0;
                  nxt_tx_pend = 1'b0;
               end else begin
                  nxt_tx_st = TX_IDLE;
               end
            end
            TX_START: begin
               nxt_tx_st = TX_DATA;
               nxt_tx_pin = tx_sh_ff[0];
               nxt_tx_sh = {1'b0, tx_sh_ff[7:1]};
               nxt_tx_cnt = 4'h1;
            end
            TX_DATA: begin
               if (tx_cnt_ff == 4'(DATA_BITS)) begin
                  if (ctrl_ff.frame9) begin
                     nxt_tx_st = TX_NINTH;
                     nxt_tx_pin = ctrl_ff.tb8;
                  end else begin
                     nxt_tx_st = TX_STOP;
                     nxt_tx_pin = 1'b1;
                     tx_set = 1'b1;
                  end
               end else begin
                  nxt_tx_pin = tx_sh_ff[0];
                  nxt_tx_sh = {1'b0, tx_sh_ff[7:1]};
                  nxt_tx_cnt = tx_cnt_ff + 4'h1;
               end
            end
            TX_NINTH: begin
               nxt_tx_st = TX_STOP;
               nxt_tx_pin = 1'b1;
               tx_set = 1'b1;
            end
            default: begin
               nxt_tx_st = TX_IDLE;
               nxt_tx_pin = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_st_ff <= TX_IDLE;
         tx_sh_ff <= DATA_RST;
         tx_cnt_ff <= '0;
         tx_pend_ff <= 1'b0;
         tx_pin_ff <= 1'b1;
      end else begin
         tx_st_ff <= nxt_tx_st;
         tx_sh_ff <= nxt_tx_sh;
         tx_cnt_ff <= nxt_tx_cnt;
         tx_pend_ff <= nxt_tx_pend;
         tx_pin_ff <= nxt_tx_pin;
      end
   end

   assign tx_pin = tx_pin_ff;

   // ***************************************************************
   // Receiver
   // ***************************************************************
   uwtb_rx_e rx_st_ff, nxt_rx_st;
   logic [7:0] rx_sh_ff, nxt_rx_sh;
   logic [3:0] rx_cnt_ff, nxt_rx_cnt;
   logic rx_b9_ff, nxt_rx_b9;
   logic rx_prev_ff;
   wire rx_chk = ctrl_ff.frame9 ? rx_b9_ff : rx_pin;

   assign rx_start_det = ctrl_ff.ren & run_ff & (rx_st_ff == RX_IDLE)
                         & rx_prev_ff & ~rx_pin;
   assign rx_load_data = rx_sh_ff;
   assign rx_load_b8 = rx_chk;

   always_comb begin
      nxt_rx_st = rx_st_ff;
      nxt_rx_sh = rx_sh_ff;
      nxt_rx_cnt = rx_cnt_ff;
      nxt_rx_b9 = rx_b9_ff;
      rx_load = 1'b0;
      rx_set = 1'b0;
      if (!ctrl_ff.ren) begin
         nxt_rx_st = RX_IDLE;
      end else if (rx_start_det) begin
         nxt_rx_st = RX_START;
      end else if (rx_baud) begin
         case (rx_st_ff)
            RX_START: begin
               nxt_rx_st = rx_pin ? RX_IDLE : RX_DATA;
               nxt_rx_cnt = 4'h0;
            end
            RX_DATA: begin
               nxt_rx_sh = {rx_pin, rx_sh_ff[7:1]};
               nxt_rx_cnt = rx_cnt_ff + 4'h1;
               if (rx_cnt_ff == 4'(DATA_BITS - 1))
                  nxt_rx_st = ctrl_ff.frame9 ? RX_NINTH : RX_STOP;
            end
            RX_NINTH: begin
               nxt_rx_b9 = rx_pin;
               nxt_rx_st = RX_STOP;
            end
            RX_STOP: begin
               nxt_rx_st = RX_IDLE;
               if (!stat_ff[STAT_RX_BIT] && (!ctrl_ff.mce || rx_chk)) begin
                  rx_load = 1'b1;
                  rx_set = 1'b1;
               end
            end
            default: nxt_rx_st = rx_st_ff;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_st_ff <= RX_IDLE;
         rx_sh_ff <= DATA_RST;
         rx_cnt_ff <= '0;
         rx_b9_ff <= 1'b0;
         rx_prev_ff <= 1'b1;
      end else begin
         rx_st_ff <= nxt_rx_st;
         rx_sh_ff <= nxt_rx_sh;
         rx_cnt_ff <= nxt_rx_cnt;
         rx_b9_ff <= nxt_rx_b9;
         rx_prev_ff <= rx_pin;
      end
   end

   // ***************************************************************
   // Read data
   // ***************************************************************
   wire [31:0] rd_ctrl = {24'h000000, ctrl_ff.frame9, UNUSED_BIT_VAL,
                          ctrl_ff.mce, ctrl_ff.ren, ctrl_ff.tb8, rb8_ff,
                          stat_ff[STAT_TX_BIT], stat_ff[STAT_RX_BIT]};
   wire [31:0] rd_tmr = {29'h00000000, src_ff, run_ff};
   wire [31:0] rd_reload = {16'h0000, low_count, reload_ff};

   assign hrdata = !rd_en ? 32'h00000000 :
                   (aph_ff.ofs == OFS_CTRL) ? rd_ctrl :
                   (aph_ff.ofs == OFS_DATA) ? {24'h000000, rxbuf_ff} :
                   (aph_ff.ofs == OFS_TMR) ? rd_tmr :
                   (aph_ff.ofs == OFS_RELOAD) ? rd_reload :
                   (aph_ff.ofs == OFS_STAT) ? {30'h00000000, stat_ff} :
                   (aph_ff.ofs == OFS_MASK) ? {30'h00000000, mask_ff} :
                   32'h00000000;
endmodule

// [uwtb_monitor.sv]
`timescale 1ns/10ps
module uwtb_monitor #(
   parameter int DATA_BITS = 8
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic ext_clk_en,
   input wire logic rx_pin,
   input wire logic tx_pin,
   input wire logic irq
);
   import uwtb_pkg::*;
   // ***************************************************************
   // Data phase tracking
   // ***************************************************************
   logic rd_dp_ff;
   logic wr_dp_ff;
   logic map_ff;
   logic [7:0] ofs_ff;
   wire take = hsel & hready & htrans[1];
   wire mapped = (hsize == HSIZE_WORD) && (haddr[31:8] == 24'h0) &&
      (haddr[7:0] <= OFS_MASK) && (haddr[1:0] == 2'h0);
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_dp_ff <= 1'b0;
         wr_dp_ff <= 1'b0;
         map_ff <= 1'b0;
         ofs_ff <= 8'h00;
      end else begin
         rd_dp_ff <= take & ~hwrite;
         wr_dp_ff <= take & hwrite;
         map_ff <= mapped;
         ofs_ff <= haddr[7:0];
      end
   end
   wire rd_ok = rd_dp_ff & map_ff;
   // ***************************************************************
   // Properties
   // ***************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   chk_okay_resp: assert property (hresp == 1'b0 && hreadyout == 1'b1)
      else $error("bus answer not OKAY without wait");
   chk_idle_rdata: assert property (!rd_dp_ff |-> hrdata == 32'h0)
      else $error("read data outside a read data phase");
   chk_unmap_rdata: assert property (rd_dp_ff && !map_ff
      |-> hrdata == 32'h0) else $error("unmapped read not zero");
   chk_data_upper: assert property (rd_ok && ofs_ff == OFS_DATA
      |-> hrdata[31:8] == 24'h0) else $error("data read upper bits set");
   chk_ctrl_fixed: assert property (rd_ok && ofs_ff == OFS_CTRL
      |-> hrdata[6] == UNUSED_BIT_VAL && hrdata[31:8] == 24'h0)
      else $error("control read fixed bits wrong");
   chk_stat_upper: assert property (rd_ok && (ofs_ff == OFS_STAT ||
      ofs_ff == OFS_MASK) |-> hrdata[31:2] == 30'h0)
      else $error("status or mask upper bits set");
   chk_irq_clear: assert property ($fell(irq) |-> $past(wr_dp_ff))
      else $error("interrupt dropped without a write");
   chk_bit_hold: assert property ($changed(tx_pin)
      |=> $stable(tx_pin)[*7])
      else $error("serial bit shorter than eight clocks");
   cover property ($fell(irq));
   cover property ($fell(tx_pin));
   cover property (rd_dp_ff && !map_ff);
endmodule
bind uwtb_top uwtb_monitor #(.DATA_BITS(DATA_BITS)) u_mon (.clk(clk),
   .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .ext_clk_en(ext_clk_en), .rx_pin(rx_pin), .tx_pin(tx_pin), .irq(irq));

// [uwtb_remote.sv]
`timescale 1ns/10ps
module uwtb_remote (
   input wire logic clk,
   input wire logic tx_pin,
   input wire logic nine,
   input wire logic [15:0] bit_len,
   output logic rx_pin
);
   // ***************************************************************
   // Frame sender and frame catcher of the far transceiver
   // ***************************************************************
   logic [9:0] got_q[$];
   initial rx_pin = 1'b1;
   task automatic send(input logic [7:0] d, input logic b9);
      logic [10:0] f;
      f = {1'b1, nine ? b9 : 1'b1, d, 1'b0};
      for (int i = 0; i < (nine ? 11 : 10); i++) begin
         rx_pin <= f[i];
         repeat (bit_len) @(posedge clk);
      end
   endtask
   // Samples mid-bit; stop lands in bit 8, the ninth-bit slot, and bit 9 stays one in 8-bit mode
   always begin
      logic [9:0] v;
      @(negedge tx_pin);
      v = 10'h3ff;
      repeat (bit_len / 2) @(posedge clk);
      for (int j = 0; j < (nine ? 10 : 9); j++) begin
         repeat (bit_len) @(posedge clk);
         v[j] = tx_pin;
      end
      got_q.push_back(v);
   end
endmodule

// [tb_top.sv]
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
 $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
   import uwtb_pkg::*;
   logic clk, sys_rst, hsel, hwrite, ext_clk_en, rx_pin, tx_pin, irq;
   logic hreadyout, hresp, frame9, mce, tb8, rb8, rx_flag;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, mask;
   logic [2:0] hsize;
   logic [15:0] bit_len;
   logic [7:0] rx_buf;
   logic [9:0] exp_q[$];
   wire hready = hreadyout;
   int miscompares = 0;
   int comparisons = 0;
   uwtb_top #(.DATA_BITS(8)) DUT (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .ext_clk_en(ext_clk_en), .rx_pin(rx_pin),
      .tx_pin(tx_pin), .irq(irq));
   uwtb_remote u_remote (.clk(clk), .tx_pin(tx_pin), .nine(frame9),
      .bit_len(bit_len), .rx_pin(rx_pin));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // External oscillator pulse every other clock
   always @(posedge clk) ext_clk_en <= ~ext_clk_en;
   // ***************************************************************
   // Tasks
   // ***************************************************************
   task automatic stop_test();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic bus(input logic [7:0] a, input logic w,
      input logic [31:0] wd, output logic [31:0] rd);
      int n;
      logic rdy;
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= HSIZE_WORD;
      for (int p = 0; p < 2; p++) begin
         n = 0;
         // Ready and read data are taken at the rising edge itself
         do begin
            @(posedge clk);
            rdy = hready;
            rd = hrdata;
            n++;
         end while (rdy !== 1'b1 && n < 64);
         if (rdy !== 1'b1) begin
            miscompares++;
            stop_test();
         end
         if (p == 0) begin
            hsel <= 1'b0;
            htrans <= 2'b00;
            hwdata <= wd;
         end
      end
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(a, 1'b1, d, x);
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      bus(a, 1'b0, 32'h0, d);
   endtask
   task automatic do_reset();
      sys_rst <= 1'b1;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_tx();
      logic [31:0] v;
      int n;
      n = 0;
      do begin
         reg_rd(OFS_STAT, v);
         n++;
      end while (v[STAT_TX_BIT] !== 1'b1 && n < 2000);
      if (v[STAT_TX_BIT] !== 1'b1) begin
         miscompares++;
         stop_test();
      end
      `CHK(tx_pin, 1'b1)
      `CHK(u_remote.got_q.size(), 0)
   endtask
   task automatic frame_pair(input logic [7:0] td, input logic [7:0] rx,
      input logic b9);
      logic [31:0] v;
      logic [9:0] got, exp;
      logic [31:0] ex;
      logic cb;
      int n;
      fork
         u_remote.send(rx, b9);
         begin
            reg_wr(OFS_DATA, {24'h0, td});
            exp_q.push_back({1'b1, frame9 ? tb8 : 1'b1, td});
            wait_tx();
         end
      join
      cb = frame9 ? b9 : 1'b1;
      if (!rx_flag && (!mce || cb)) begin
         rx_buf = rx;
         rb8 = cb;
         rx_flag = 1'b1;
      end
      n = 0;
      while (u_remote.got_q.size() == 0 && n < 4000) begin
         @(posedge clk);
         n++;
      end
      if (u_remote.got_q.size() == 0) begin
         miscompares++;
         stop_test();
      end
      got = u_remote.got_q.pop_front();
      exp = exp_q.pop_front();
      `CHK(got, exp)
      reg_rd(OFS_CTRL, v);
      // Mode, fixed one, check enable, receive enable, ninth bits, flags
      ex = {24'h0, frame9, 1'b1, mce, 1'b1, tb8, rb8, 1'b1, rx_flag};
      `CHK(v, ex)
      `CHK(irq, (|(mask & {1'b1, rx_flag})))
      reg_rd(OFS_DATA, v);
      `CHK(v, ({24'h0, rx_buf}))
      reg_wr(OFS_STAT, 32'h2);
   endtask
   task automatic clear_rx();
      reg_wr(OFS_STAT, 32'h1);
      rx_flag = 1'b0;
      // Let the clearing edge settle before looking at the interrupt
      @(posedge clk);
      `CHK(irq, 1'b0)
   endtask
   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      logic [31:0] v;
      logic [7:0] rl;
      int dv[4] = '{4, 12, 48, 16};
      logic [31:0] rst_tab[6] = '{32'h40, 0, 0, 0, 0, 0};
      {hsel, hwrite, ext_clk_en, frame9, mce, tb8, rb8, rx_flag} = 8'h00;
      {haddr, hwdata, htrans, hsize, mask, rx_buf} = '0;
      bit_len = 16'h8;
      void'($urandom(32'h80f6198e));
      do_reset();
      for (int i = 0; i < 6; i++) begin
         reg_rd(8'(i * 4), v);
         `CHK(v, rst_tab[i])
      end
      reg_wr(8'h18, 32'hffffffff);
      reg_rd(8'h18, v);
      `CHK(v, 32'h0)
      mask = 2'h3;
      reg_wr(OFS_MASK, 32'h3);
      for (int s = 0; s < 4; s++) begin
         rl = 8'hff - 8'($urandom % 2);
         bit_len = 16'(2 * dv[s] * (256 - rl));
         reg_wr(OFS_RELOAD, {24'h0, rl});
         reg_wr(OFS_TMR, 32'(s * 2 + 1));
         reg_wr(OFS_CTRL, 32'h10);
         frame_pair(8'($urandom), 8'($urandom), 1'b0);
         clear_rx();
      end
      {frame9, mce, tb8, mask} = 5'h1c;
      reg_wr(OFS_MASK, 32'h0);
      reg_wr(OFS_TMR, 32'h1);
      reg_wr(OFS_RELOAD, 32'hff);
      bit_len = 16'h8;
      reg_wr(OFS_CTRL, 32'hb8);
      frame_pair(8'($urandom), 8'($urandom), 1'b0);
      frame_pair(8'($urandom), 8'($urandom), 1'b1);
      frame_pair(8'($urandom), 8'($urandom), 1'b1);
      clear_rx();
      {mce, tb8} = 2'b00;
      reg_wr(OFS_CTRL, 32'h90);
      frame_pair(8'($urandom), 8'($urandom), 1'b0);
      clear_rx();
      do_reset();
      reg_rd(OFS_CTRL, v);
      `CHK(v, 32'h40)
      `CHK(irq, 1'b0)
      stop_test();
   end
endmodule
